// ==== rtl/cse_status_irq.sv ====
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module cse_status_irq
   import cse_pkg::*;
#(
   parameter int WDOG_CYCLES = WDOG_CYC,
   parameter int STARTUP_CYCLES = STARTUP_CYC
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic halt_exec,
   input wire logic mask_all_instruction,
   input wire logic unmask_all_instruction,
   input wire logic return_from_service_instruction,
   input wire logic instr_done,
   input wire logic watchdog_expired,
   input wire logic usb_dp,
   input wire logic usb_dm,
   input wire logic [4:0] endpoint_event,
   input wire logic hub_event,
   input wire logic converter_event,
   input wire logic serial_event,
   input wire logic [7:0] gpio_pins,
   output logic cpu_run,
   output logic cpu_suspended,
   output logic watchdog_reset_pulse,
   output logic service_call,
   output logic [15:0] service_vector_addr
);

   // ************************************************************
   // Functions
   // ************************************************************
   function automatic logic [3:0] lowest_set(input logic [NUM_SRC-1:0] v);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--)
      begin
         if (v[i])
         begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction : lowest_set

   // ************************************************************
   // State
   // ************************************************************
   logic run;
   logic suspend;
   logic por_flag;
   logic busrst_flag;
   logic wdr_flag;
   logic gie;
   logic [7:0] global_source_enables;
   logic [7:0] endpoint_source_enables;
   logic [NUM_SRC-1:0] pend;
   logic [1:0] dp_sync;
   logic [1:0] dm_sync;
   logic [7:0] gpio_meta;
   logic [7:0] gpio_sync;
   logic [7:0] gpio_prev;
   logic dp_prev;
   logic dm_prev;
   logic [7:0] se0_count;
   logic se0_seen;
   logic [10:0] t128_count;
   logic [2:0] t1024_count;
   cse_boot_t boot_state;
   cse_boot_t next_boot_state;
   logic [19:0] boot_count;
   logic [NUM_SRC-1:0] src_set;
   logic [NUM_SRC-1:0] src_en;
   logic [NUM_SRC-1:0] req;
   logic [NUM_SRC-1:0] clr_onehot;
   logic wdr_event;
   logic se0;
   logic bus_activity;
   logic busrst_detect;
   logic t128_tick;
   logic do_service;
   logic wr_access;
   logic wr_psc;
   logic wr_gen;
   logic wr_een;
   logic addr_ok;
   logic [7:0] reg_idx;
   logic [7:0] psc_read;
   logic [7:0] read_mux;

   // ************************************************************
   // Pin synchronisers and link events
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dp_sync <= 2'h3;
         dm_sync <= 2'h0;
         dp_prev <= 1'b1;
         dm_prev <= 1'b0;
         gpio_meta <= 8'h00;
         gpio_sync <= 8'h00;
         gpio_prev <= 8'h00;
      end
      else
      begin
         dp_sync <= {dp_sync[0], usb_dp};
         dm_sync <= {dm_sync[0], usb_dm};
         dp_prev <= dp_sync[1];
         dm_prev <= dm_sync[1];
         gpio_meta <= gpio_pins;
         gpio_sync <= gpio_meta;
         gpio_prev <= gpio_sync;
      end
   end

   assign se0 = !dp_sync[1] && !dm_sync[1];
   // Any line change or a single-ended zero counts as bus activity.
   assign bus_activity = se0 || (dp_sync[1] != dp_prev) || (dm_sync[1] != dm_prev);

   // [R08] SE0 length count
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         se0_count <= 8'h00;
         se0_seen <= 1'b0;
      end
      else if (!se0)
      begin
         se0_count <= 8'h00;
         se0_seen <= 1'b0;
      end
      else if (se0_count < 8'(BUSRST_CYC))
      begin
         se0_count <= se0_count + 8'h01;
      end
      else
      begin
         se0_seen <= 1'b1;
      end
   end

   assign busrst_detect = se0 && (se0_count == 8'(BUSRST_CYC)) && !se0_seen;

   // [R16] Periodic timers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         t128_count <= 11'h000;
         t1024_count <= 3'h0;
      end
      else if (t128_tick)
      begin
         t128_count <= 11'h000;
         t1024_count <= t1024_count + 3'h1;
      end
      else
      begin
         t128_count <= t128_count + 11'h001;
      end
   end

   assign t128_tick = (t128_count == 11'(T128_CYC - 1));

   // ************************************************************
   // Start-up suspend and watchdog reset
   // ************************************************************
   always_comb
   begin
      next_boot_state = boot_state;
      case (boot_state)
         BOOT_SUSPEND:
         begin
            if (busrst_detect || boot_count == 20'(STARTUP_CYCLES - 1))
            begin
               next_boot_state = BOOT_RUN;
            end
         end
         BOOT_RUN:
         begin
            next_boot_state = BOOT_RUN;
         end
         default:
         begin
            next_boot_state = BOOT_RUN;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         boot_state <= BOOT_SUSPEND;
         boot_count <= 20'h00000;
      end
      else
      begin
         boot_state <= next_boot_state;
         if (boot_state == BOOT_SUSPEND)
         begin
            boot_count <= boot_count + 20'h00001;
         end
      end
   end

   // [R12] Watchdog fires in start-up suspend unless aborted first
   assign wdr_event = watchdog_expired
      || (boot_state == BOOT_SUSPEND && !busrst_detect
          && boot_count == 20'(WDOG_CYCLES - 1));

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         watchdog_reset_pulse <= 1'b0;
      end
      else
      begin
         watchdog_reset_pulse <= wdr_event;
      end
   end

   // ************************************************************
   // APB slave
   // ************************************************************
   assign reg_idx = paddr[9:2];
   assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0)
      && (reg_idx == IDX_GLOBAL_EN || reg_idx == IDX_ENDPOINT_EN
          || reg_idx == IDX_PROC_STATE);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign wr_access = psel && penable && pwrite && addr_ok && pstrb[0];
   assign wr_psc = wr_access && reg_idx == IDX_PROC_STATE;
   assign wr_gen = wr_access && reg_idx == IDX_GLOBAL_EN;
   assign wr_een = wr_access && reg_idx == IDX_ENDPOINT_EN;

   // [R10] Bit seven mirrors any pending source
   always_comb
   begin
      psc_read = 8'h00;
      psc_read[BIT_RUN] = run;
      psc_read[BIT_GIE] = gie;
      psc_read[BIT_SUSPEND] = suspend;
      psc_read[BIT_POR] = por_flag;
      psc_read[BIT_BUSRST] = busrst_flag;
      psc_read[BIT_WDR] = wdr_flag;
      psc_read[BIT_IRQ] = |pend;
   end

   always_comb
   begin
      case (reg_idx)
         IDX_GLOBAL_EN: read_mux = global_source_enables;
         IDX_ENDPOINT_EN: read_mux = endpoint_source_enables;
         IDX_PROC_STATE: read_mux = psc_read;
         default: read_mux = 8'h00;
      endcase
   end

   // Read data is captured in the setup phase so the access phase answers at once.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
      end
      else if (psel && !penable && !pwrite)
      begin
         prdata <= addr_ok ? {24'h000000, read_mux} : 32'h00000000;
      end
   end

   // ************************************************************
   // Enable registers
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         global_source_enables <= RST_GLOBAL_EN;
         endpoint_source_enables <= RST_ENDPOINT_EN;
      end
      else if (wdr_event)
      begin
         global_source_enables <= RST_GLOBAL_EN;
         endpoint_source_enables <= RST_ENDPOINT_EN;
      end
      else
      begin
         // [R23] Reserved bits masked
         if (wr_gen)
         begin
            global_source_enables <= pwdata[7:0] & MASK_GLOBAL_EN;
         end
         // [R19] Endpoint enables
         if (wr_een)
         begin
            endpoint_source_enables <= pwdata[7:0] & MASK_ENDPOINT_EN;
         end
      end
   end

   // ************************************************************
   // Pending sources and service
   // ************************************************************
   // [R17] Either edge on any pin
   assign src_set = {serial_event, |(gpio_sync ^ gpio_prev), converter_event, hub_event,
      endpoint_event, t128_tick && t1024_count == 3'(T1024_PER_T128 - 1), t128_tick,
      se0_seen && !se0};

   // [R15] One enable per source
   // [R18] Global bit assignment
   assign src_en = {global_source_enables[GEN_SERIAL], global_source_enables[GEN_GPIO],
      global_source_enables[GEN_DAC], global_source_enables[GEN_HUB],
      endpoint_source_enables[4:0], global_source_enables[GEN_T1024],
      global_source_enables[GEN_T128], global_source_enables[GEN_BUSRST]};

   // [R20] Requests only from enabled pending flops
   assign req = pend & src_en;
   assign do_service = instr_done && gie && run && |req;
   // [R21] Lowest vector first
   assign clr_onehot = do_service ? (NUM_SRC'(1) << lowest_set(req)) : '0;

   // [R20] Sticky pending; a new event wins over the service clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pend <= '0;
      end
      else if (wdr_event || halt_exec)
      begin
         pend <= '0;
      end
      else
      begin
         pend <= (pend & ~clr_onehot) | src_set;
      end
   end

   // [R22] Call to the vector of the serviced source
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         service_call <= 1'b0;
         service_vector_addr <= 16'h0000;
      end
      else
      begin
         service_call <= do_service;
         if (do_service)
         begin
            service_vector_addr <= {11'h000, lowest_set(req) + 4'h1, 1'b0};
         end
      end
   end

   // ************************************************************
   // Processor status and control
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      // [R11] Power-up value
      if (!presetn)
      begin
         run <= RST_PROC_STATE[BIT_RUN];
         suspend <= RST_PROC_STATE[BIT_SUSPEND];
         gie <= RST_PROC_STATE[BIT_GIE];
      end
      // [R13] Watchdog reset restarts
      else if (wdr_event)
      begin
         run <= 1'b1;
         suspend <= 1'b0;
         gie <= 1'b0;
      end
      // [R01] Halt clears everything
      else if (halt_exec)
      begin
         run <= 1'b0;
         suspend <= 1'b0;
         gie <= 1'b0;
      end
      else
      begin
         // [R02] Run can be dropped by a write but never set again
         if (wr_psc && !pwdata[BIT_RUN])
         begin
            run <= 1'b0;
         end
         // [R05] Wake on enabled pending interrupt or bus activity
         if (suspend && (|req || bus_activity))
         begin
            suspend <= 1'b0;
         end
         // [R06] Suspend refused during bus activity
         else if (wr_psc && pwdata[BIT_SUSPEND] && !bus_activity)
         begin
            suspend <= 1'b1;
         end
         // [R04] Only the instructions and service move the global enable
         if (do_service || mask_all_instruction)
         begin
            gie <= 1'b0;
         end
         else if (unmask_all_instruction || return_from_service_instruction)
         begin
            gie <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      // [R07] Power-up flag
      if (!presetn)
      begin
         por_flag <= RST_PROC_STATE[BIT_POR];
         busrst_flag <= RST_PROC_STATE[BIT_BUSRST];
         wdr_flag <= RST_PROC_STATE[BIT_WDR];
      end
      else if (halt_exec && !wdr_event)
      begin
         por_flag <= 1'b0;
         busrst_flag <= 1'b0;
         wdr_flag <= 1'b0;
      end
      else
      begin
         if (wr_psc)
         begin
            por_flag <= pwdata[BIT_POR];
            wdr_flag <= pwdata[BIT_WDR];
         end
         // [R09] Watchdog flag
         if (wdr_event)
         begin
            wdr_flag <= 1'b1;
         end
         // [R08] Bus reset flag, set wins over a write
         if (busrst_detect)
         begin
            busrst_flag <= 1'b1;
         end
         else if (wr_psc)
         begin
            busrst_flag <= pwdata[BIT_BUSRST];
         end
      end
   end

   assign cpu_run = run && !suspend && boot_state == BOOT_RUN;
   assign cpu_suspended = suspend || boot_state == BOOT_SUSPEND;

endmodule : cse_status_irq

// ==== rtl/cse_pkg.sv ====
// What this block does
// [R01] Halt instruction clears the whole status register, stopping the processor.
// [R02] A halted processor restarts only on power-on or watchdog reset.
// [R03] Firmware writes zero to status bit one and normally one to run.
// [R04] Status bit two shows the global enable; writes do nothing.
// [R05] Writing suspend stops the processor until an enabled interrupt or bus activity.
// [R06] A suspend write is ignored while bus activity is present.
// [R07] Power-on reset sets the power-up flag at bit four.
// [R08] Bus reset flag sets when both data lines stay low 12 to 16 us.
// [R09] Watchdog reset flag sets on any reset caused by the watchdog.
// [R10] Bit seven reads one while any interrupt is pending.
// [R11] Power-up loads the status register with 00010001.
// [R12] Start-up suspend also gives a watchdog reset unless bus reset aborts it early.
// [R13] Watchdog reset loads 01XX0001, keeping power-up and bus-reset flags.
// [R14] Firmware should clear the power-up flag after checking it.
// [R15] Every source is masked by one enable bit; one enables it.
// [R16] Global bits one and two gate the 128 us and 1.024 ms timers.
// [R17] Global bit five gates the pin interrupt, raised on either pin edge.
// [R18] Global bits zero, three, four, six gate bus reset, hub, converter, serial.
// [R19] Endpoint bits zero to four gate the five endpoints; all reset to zero.
// [R20] Each source has a sticky pending flop; it requests only when enabled.
// [R21] The lowest-numbered vector wins among simultaneous requests.
// [R22] Servicing clears global enable and the pending flop, and calls the vector.
// [R23] Reserved enable bits ignore writes and read as zero.
package cse_pkg;

   // ************************************************************
   // Register map (indices; byte address is four times the index)
   // ************************************************************
   localparam logic [7:0] IDX_GLOBAL_EN = 8'h20;
   localparam logic [7:0] IDX_ENDPOINT_EN = 8'h21;
   localparam logic [7:0] IDX_PROC_STATE = 8'hFF;

   localparam logic [7:0] RST_GLOBAL_EN = 8'h00;
   localparam logic [7:0] RST_ENDPOINT_EN = 8'h00;
   localparam logic [7:0] RST_PROC_STATE = 8'h11;
   localparam logic [7:0] MASK_GLOBAL_EN = 8'h7F;
   localparam logic [7:0] MASK_ENDPOINT_EN = 8'h1F;

   // ************************************************************
   // Status register fields
   // ************************************************************
   localparam int BIT_RUN = 0;
   localparam int BIT_RSVD = 1;
   localparam int BIT_GIE = 2;
   localparam int BIT_SUSPEND = 3;
   localparam int BIT_POR = 4;
   localparam int BIT_BUSRST = 5;
   localparam int BIT_WDR = 6;
   localparam int BIT_IRQ = 7;

   // ************************************************************
   // Global enable fields
   // ************************************************************
   localparam int GEN_BUSRST = 0;
   localparam int GEN_T128 = 1;
   localparam int GEN_T1024 = 2;
   localparam int GEN_HUB = 3;
   localparam int GEN_DAC = 4;
   localparam int GEN_GPIO = 5;
   localparam int GEN_SERIAL = 6;
   localparam int NUM_SRC = 12;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int BUSRST_MIN_NS = 12000;
   localparam int BUSRST_CYC = (BUSRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T128_NS = 128000;
   localparam int T128_CYC = T128_NS / CLK_PERIOD_NS;
   localparam int T1024_PER_T128 = 8;
   localparam int WDOG_MS = 8;
   localparam int WDOG_CYC = (WDOG_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STARTUP_MS = 96;
   localparam int STARTUP_CYC = (STARTUP_MS * 1000000) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      BOOT_SUSPEND = 2'b00,
      BOOT_RUN = 2'b01
   } cse_boot_t;

endpackage : cse_pkg

// ==== bench/cse_status_irq_props.sv ====
`timescale 1ns/100ps
module cse_status_irq_props
   import cse_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic halt_exec,
   input wire logic instr_done,
   input wire logic watchdog_expired,
   input wire logic cpu_run,
   input wire logic cpu_suspended,
   input wire logic watchdog_reset_pulse,
   input wire logic service_call,
   input wire logic [15:0] service_vector_addr
);
   // ****************
   // Port relations
   // ****************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   addr_decode_a:
      assert property (psel && penable |-> pslverr == !(paddr inside {12'h080, 12'h084, 12'h3FC}))
      else $error("slave error disagrees with decode");
   bad_read_a:
      assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
      else $error("refused read returned data");
   halt_stop_a:
      assert property (halt_exec && !watchdog_expired |=> !cpu_run)
      else $error("core still runs after halt");
   halt_hold_a:
      assert property (!cpu_run && !cpu_suspended && !watchdog_expired |=> !cpu_run)
      else $error("halted core restarted without reset");
   run_excl_a:
      assert property (cpu_run |-> !cpu_suspended)
      else $error("core runs while suspended");
   svc_cause_a:
      assert property (service_call |-> $past(instr_done))
      else $error("service without instruction end");
   svc_single_a:
      assert property (service_call |=> !service_call)
      else $error("service call longer than one cycle");
   vec_range_a:
      assert property (service_call |-> service_vector_addr inside {[16'h0002:16'h0018]}
         && !service_vector_addr[0])
      else $error("vector address outside table");
   vec_hold_a:
      assert property (!$stable(service_vector_addr) |-> service_call)
      else $error("vector changed without service");
   wdog_pulse_a:
      assert property (watchdog_expired |-> ##[1:2] watchdog_reset_pulse)
      else $error("watchdog reset not reported");

   cover property (service_call);
   cover property (watchdog_reset_pulse);
   cover property (psel && penable && pslverr);
endmodule : cse_status_irq_props

bind cse_status_irq cse_status_irq_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
   .halt_exec(halt_exec), .instr_done(instr_done), .watchdog_expired(watchdog_expired),
   .cpu_run(cpu_run), .cpu_suspended(cpu_suspended), .watchdog_reset_pulse(watchdog_reset_pulse),
   .service_call(service_call), .service_vector_addr(service_vector_addr));

// ==== bench/cse_cpu_model.sv ====
`timescale 1ns/100ps
module cse_cpu_model
   import cse_pkg::*;
#(
   parameter int GAP = 3,
   parameter int RET_DELAY = 3
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cpu_run,
   input wire logic service_call,
   output logic instr_done,
   output logic return_from_service_instruction
);
   // ****************
   // Core model
   // ****************
   int gap_cnt;
   int ret_cnt;

   // A large GAP models slow multi-cycle instructions; nothing finishes while stopped.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gap_cnt <= 0;
         instr_done <= 1'b0;
      end
      else
      begin
         gap_cnt <= (gap_cnt >= GAP - 1) ? 0 : gap_cnt + 1;
         instr_done <= cpu_run && (gap_cnt == 0);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ret_cnt <= 0;
         return_from_service_instruction <= 1'b0;
      end
      else
      begin
         ret_cnt <= service_call ? RET_DELAY : (ret_cnt != 0) ? ret_cnt - 1 : 0;
         return_from_service_instruction <= (ret_cnt == 1);
      end
   end
endmodule : cse_cpu_model

// ==== bench/cse_status_irq_tb.sv ====
`timescale 1ns/100ps
`define CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("ERROR %0t: got %0h exp %0h", $time, g, e); end end
module cse_status_irq_tb
   import cse_pkg::*;
;
   localparam logic [11:0] AS = {2'b00, IDX_PROC_STATE, 2'b00};
   localparam logic [11:0] AG = {2'b00, IDX_GLOBAL_EN, 2'b00};
   localparam logic [11:0] AE = {2'b00, IDX_ENDPOINT_EN, 2'b00};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rfs, idone, dp, dm, err;
   logic run, susp, wpulse, svc;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [12:0] pl;
   logic [7:0] rd;
   logic [15:0] vec;
   logic [15:0] vq[$];
   int bad_count, tests_run, cycles;

   cse_status_irq #(.WDOG_CYCLES(50), .STARTUP_CYCLES(200)) uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr), .halt_exec(pl[0]),
      .mask_all_instruction(pl[1]), .unmask_all_instruction(pl[2]),
      .return_from_service_instruction(rfs), .instr_done(idone), .watchdog_expired(pl[3]),
      .usb_dp(dp), .usb_dm(dm), .endpoint_event(pl[12:8]), .hub_event(pl[4]),
      .converter_event(pl[5]), .serial_event(pl[7]), .gpio_pins({8{pl[6]}}), .cpu_run(run),
      .cpu_suspended(susp), .watchdog_reset_pulse(wpulse), .service_call(svc),
      .service_vector_addr(vec));
   cse_cpu_model #(.GAP(3), .RET_DELAY(3)) u_cpu (.pclk(pclk), .presetn(presetn), .cpu_run(run),
      .service_call(svc), .instr_done(idone), .return_from_service_instruction(rfs));

   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   always @(negedge pclk)
   begin
      cycles++;
      if (svc === 1'b1)
         vq.push_back(vec);
      if (cycles == 40000)
      begin
         bad_count++;
         $display("ERROR %0t: timeout", $time);
         finish_test();
      end
   end

   // ****************
   // Bus and stimulus
   // ****************
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rdchk(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
      apb(1'b0, a, 8'h00);
      `CHECK(rd & m, e)
   endtask : rdchk

   task pulse(input logic [12:0] v);
      @(posedge pclk);
      pl <= v;
      @(posedge pclk);
      pl <= 13'h0;
   endtask : pulse

   task expect_vec(input logic [15:0] e, input int lim);
      int n;
      logic [15:0] g;
      n = 0;
      while (vq.size() == 0 && n < lim)
      begin
         @(negedge pclk);
         n++;
      end
      g = (vq.size() > 0) ? vq.pop_front() : 16'hFFFF;
      `CHECK(g, e)
   endtask : expect_vec

   task wait_run(input int lim);
      int n;
      n = 0;
      while (run !== 1'b1 && n < lim)
      begin
         @(negedge pclk);
         n++;
      end
      `CHECK(run, 1'b1)
   endtask : wait_run

   task finish_test;
      $display("Checks: %0d, errors: %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test

   // ****************
   // Scenarios
   // ****************
   task t_startup;
      rdchk(AS, 8'h11, 8'hFF);
      rdchk(AE, 8'h00, 8'hFF);
      repeat (60) @(posedge pclk);
      rdchk(AS, 8'h51, 8'hFF);
      wait_run(300);
   endtask : t_startup

   task t_regs;
      apb(1'b1, AG, 8'hFF);
      rdchk(AG, 8'h7F, 8'hFF);
      apb(1'b1, AE, 8'hFF);
      rdchk(AE, 8'h1F, 8'hFF);
      apb(1'b0, 12'h088, 8'h00);
      `CHECK({err, rd}, 9'h100)
      apb(1'b1, AG, 8'h00);
      apb(1'b1, AS, 8'h05);
      rdchk(AS, 8'h01, 8'hFF);
      pulse(13'h004);
      rdchk(AS, 8'h05, 8'hFF);
      pulse(13'h002);
      rdchk(AS, 8'h01, 8'hFF);
   endtask : t_regs

   task t_irq;
      vq.delete();
      pulse(13'h900);
      rdchk(AS, 8'h81, 8'hFF);
      pulse(13'h004);
      expect_vec(16'h0008, 20);
      expect_vec(16'h000E, 40);
      rdchk(AS, 8'h01, 8'hFB);
      apb(1'b1, AE, 8'h00);
      pulse(13'h004);
      pulse(13'h200);
      repeat (20) @(negedge pclk);
      `CHECK(vq.size(), 0)
      rdchk(AS, 8'h85, 8'hFF);
      apb(1'b1, AE, 8'h02);
      expect_vec(16'h000A, 20);
      apb(1'b1, AE, 8'h00);
   endtask : t_irq

   task t_sources;
      vq.delete();
      for (int i = 0; i < 4; i++)
      begin
         // Both pin edges land while masked, so the pin source is serviced once.
         pulse(13'h010 << i);
         apb(1'b1, AG, 8'h08 << i);
         pulse(13'h004);
         expect_vec(16'h0012 + 16'(2 * i), 30);
      end
      apb(1'b1, AG, 8'h02);
      expect_vec(16'h0004, 1400);
      apb(1'b1, AG, 8'h04);
      expect_vec(16'h0006, 10400);
      apb(1'b1, AG, 8'h00);
   endtask : t_sources

   task t_busreset;
      @(posedge pclk);
      dp <= 1'b0;
      repeat (60) @(posedge pclk);
      dp <= 1'b1;
      rdchk(AS, 8'h00, 8'h20);
      dp <= 1'b0;
      repeat (130) @(posedge pclk);
      dp <= 1'b1;
      rdchk(AS, 8'h20, 8'h20);
      vq.delete();
      apb(1'b1, AG, 8'h01);
      expect_vec(16'h0002, 30);
      apb(1'b1, AG, 8'h00);
   endtask : t_busreset

   task t_suspend;
      pulse(13'h002);
      dp <= 1'b0;
      repeat (3) @(posedge pclk);
      apb(1'b1, AS, 8'h09);
      @(negedge pclk);
      `CHECK(susp, 1'b0)
      @(posedge pclk);
      dp <= 1'b1;
      repeat (6) @(posedge pclk);
      apb(1'b1, AS, 8'h09);
      @(negedge pclk);
      `CHECK({susp, run}, 2'b10)
      @(posedge pclk);
      dp <= 1'b0;
      dm <= 1'b1;
      wait_run(20);
      @(posedge pclk);
      dp <= 1'b1;
      dm <= 1'b0;
      repeat (6) @(posedge pclk);
      apb(1'b1, AE, 8'h04);
      apb(1'b1, AS, 8'h09);
      @(negedge pclk);
      `CHECK(susp, 1'b1)
      pulse(13'h400);
      wait_run(20);
      apb(1'b1, AE, 8'h00);
   endtask : t_suspend

   task t_wdog_halt;
      apb(1'b1, AS, 8'h31);
      apb(1'b1, AG, 8'h02);
      pulse(13'h008);
      @(negedge pclk);
      `CHECK(wpulse, 1'b1)
      rdchk(AS, 8'h71, 8'h7F);
      rdchk(AG, 8'h00, 8'hFF);
      pulse(13'h001);
      rdchk(AS, 8'h00, 8'h7F);
      repeat (30) @(negedge pclk);
      `CHECK(run, 1'b0)
      pulse(13'h008);
      wait_run(20);
      rdchk(AS, 8'h41, 8'h7F);
   endtask : t_wdog_halt

   initial
   begin
      {presetn, psel, penable, pwrite, dm, err} = 6'h0;
      {paddr, pwdata, pl} = '0;
      dp = 1'b1;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_startup();
      t_regs();
      t_irq();
      t_sources();
      t_busreset();
      t_suspend();
      t_wdog_halt();
      finish_test();
   end
endmodule : cse_status_irq_tb
